// ---- rtl/pcw_map.svh ----
// Purpose: Constants of the dual measurement unit control word decoder.
// Assumes: One 16-bit word per frame, first bit shifted in is bit 15.
// Notes:   Summary below is kept short on purpose.
`ifndef PCW_MAP_SVH
`define PCW_MAP_SVH

`define PCW_WORD_W    16
`define PCW_CNT_W     8
`define PCW_CTL_HI    12
`define PCW_CTL_LO    4
`define PCW_ADDR_LO   2
`define PCW_XFER_LO   0
`define PCW_RS_EXT    3'h6
`define PCW_IDX_2UA   3'h0
`define PCW_IDX_20UA  3'h1
`define PCW_IDX_200UA 3'h2
`define PCW_IDX_2MA   3'h3
`define PCW_IDX_25MA  3'h4
`define PCW_IDX_EXT   3'h5

`endif

// ---- rtl/pcw_pkg.sv ----
// Purpose: Types shared by the control word decoder modules.
// Assumes: The constants header is on the include path.
// Notes:   Field order of the control record matches word bits 12..4.
`include "pcw_map.svh"

package pcw_pkg;

    typedef struct packed {
        logic [2:0] range_sel;          // range_sel_bit2..range_sel_bit0
        logic       measure_float_bit;
        logic       clamp_enable_bit;
        logic       force_drive;        // Low selects force_nothing_mode.
        logic       force_current_mode; // Low is force_voltage_mode.
        logic       measure_voltage_mode; // Low is measure_current_mode.
        logic       input_sel;
    } pcw_ctl_t;

    typedef struct packed {
        logic                   cs_s1;
        logic                   cs_s2;
        logic                   cs_prev;
        logic                   ld_s1;
        logic                   ld_s2;
        logic                   cen_s1;
        logic                   cen_s2;
        logic [1:0]             fp_s1;
        logic [1:0]             fp_s2;
        logic [1:0]             up_s1;
        logic [1:0]             up_s2;
        logic [1:0]             lo_s1;
        logic [1:0]             lo_s2;
        logic [`PCW_CNT_W-1:0]  cnt_s1;
        logic [`PCW_CNT_W-1:0]  cnt_s2;
        logic [`PCW_CNT_W-1:0]  cnt_snap;
        pcw_ctl_t [1:0]         in_reg;
        pcw_ctl_t [1:0]         pmu_reg;
        logic [1:0][2:0]        range_idx;
        logic [1:0]             boost;
        logic [1:0]             clamp;
        logic [1:0]             f_oe;
        logic [1:0]             f_cur;
        logic [1:0]             in_sel;
        logic [1:0]             m_oe;
        logic [1:0]             m_cur;
        logic [1:0]             h_oe;
        logic [1:0]             l_oe;
        logic [1:0]             od_low;
    } pcw_state_t;

    localparam pcw_state_t PCW_STATE_RST = '{
        cs_s1:   1'b1,
        cs_s2:   1'b1,
        cs_prev: 1'b1,
        ld_s1:   1'b1,
        ld_s2:   1'b1,
        default: '0
    };

    typedef struct packed {
        logic [`PCW_WORD_W-1:0] shreg;
        logic [`PCW_CNT_W-1:0]  count;
        logic [`PCW_CNT_W-1:0]  gray;
    } pcw_link_t;

    function automatic logic [2:0] pcw_range_idx(input logic [2:0] rs);
        logic [2:0] idx;
        idx = `PCW_IDX_2UA;
        case (rs)
            3'h0, 3'h1: idx = `PCW_IDX_2UA;
            3'h2:       idx = `PCW_IDX_20UA;
            3'h3:       idx = `PCW_IDX_200UA;
            3'h4:       idx = `PCW_IDX_2MA;
            3'h6:       idx = `PCW_IDX_EXT;
            default:    idx = `PCW_IDX_25MA;
        endcase
        return idx;
    endfunction : pcw_range_idx

endpackage : pcw_pkg

// ---- rtl/pcw_ser_if.sv ----
// Purpose: Carries the serial front end results to the decoder core.
// Assumes: word is stable whenever the frame select is high.
// Notes:   edge_gray is gray coded so it may be sampled in another domain.
`include "pcw_map.svh"

interface pcw_ser_if;
    logic [`PCW_WORD_W-1:0] word;
    logic [`PCW_CNT_W-1:0]  edge_gray;
    logic                   dout;

    modport front (output word, output edge_gray, output dout);
    modport core  (input word, input edge_gray, input dout);
endinterface : pcw_ser_if

// ---- rtl/pcw_serial_front.sv ----
// Purpose: Serial shift register on the link clock with the daisy output.
// Assumes: Data and select are synchronous to the link clock.
// Notes:   Reset acts without the link clock since it may stand still.
`include "pcw_map.svh"

module pcw_serial_front
    import pcw_pkg::*;
(
    input  wire logic sclk_in,
    input  wire logic rst_in,
    input  wire logic din_in,
    input  wire logic cs_n_in,
    pcw_ser_if.front  bus
);

    pcw_link_t l_q;
    pcw_link_t l_d;
    logic      dout_q;

    always_comb begin
        l_d = l_q;
        if (!cs_n_in) begin
            l_d.shreg = {l_q.shreg[`PCW_WORD_W-2:0], din_in};
            l_d.count = l_q.count + 1'b1;
        end
        l_d.gray = l_d.count ^ (l_d.count >> 1);
    end

    always_ff @(posedge sclk_in or posedge rst_in) begin
        if (rst_in) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    // Last stage leaves on the falling edge: half a clock after bit 16.
    always_ff @(negedge sclk_in or posedge rst_in) begin
        if (rst_in) begin
            dout_q <= 1'b0;
        end else begin
            dout_q <= l_q.shreg[`PCW_WORD_W-1];
        end
    end

    assign bus.word      = l_q.shreg;
    assign bus.edge_gray = l_q.gray;
    assign bus.dout      = dout_q;

    // The falling edge copy must still match the stage at the next rise.
    daisy_stage_a: assert property (
        @(posedge sclk_in) disable iff (rst_in)
        dout_q == l_q.shreg[`PCW_WORD_W-1])
        else $error("daisy output does not show the last stage");

endmodule : pcw_serial_front

// ---- rtl/pcw_ctrl_top.sv ----
// Purpose: Decodes the dual unit control word and drives unit controls.
// Assumes: Pins and comparator levels are asynchronous to clock_in.
// Notes:   The link clock logic is not frozen by ce_in.
`include "pcw_map.svh"

module pcw_ctrl_top
    import pcw_pkg::*;
(
    input  wire logic             clock_in,
    input  wire logic             rst_in,
    input  wire logic             ce_in,
    input  wire logic             sclk_in,
    input  wire logic             din_in,
    input  wire logic             cs_n_in,
    input  wire logic             load_n_in,
    input  wire logic             comp_enable_in,
    input  wire logic [1:0]       measure_float_pin_in,
    input  wire logic [1:0]       upper_threshold_in,
    input  wire logic [1:0]       lower_threshold_in,
    output logic                  dout_out,
    output logic [1:0][2:0]       range_sel_out,
    output logic [1:0]            booster_select_out,
    output logic [1:0]            clamp_enable_out,
    output logic [1:0]            force_oe_out,
    output logic [1:0]            force_current_mode_out,
    output logic [1:0]            input_sel_out,
    output logic [1:0]            measure_oe_out,
    output logic [1:0]            measure_current_mode_out,
    output logic [1:0]            high_flag_out,
    output logic [1:0]            high_flag_oe_out,
    output logic [1:0]            low_flag_out,
    output logic [1:0]            low_flag_oe_out
);

    pcw_ser_if  ser ();
    pcw_state_t q;
    pcw_state_t n;
    pcw_ctl_t   new_ctl;
    logic       cs_fall;
    logic       cs_rise;
    logic       quiet;

    pcw_serial_front u_front (
        .sclk_in (sclk_in),
        .rst_in  (rst_in),
        .din_in  (din_in),
        .cs_n_in (cs_n_in),
        .bus     (ser.front)
    );

    assign cs_fall = q.cs_prev & ~q.cs_s2;
    assign cs_rise = ~q.cs_prev & q.cs_s2;
    // Equal edge counts at both select edges means no clock in the frame.
    assign quiet   = (q.cnt_s2 == q.cnt_snap);
    // The word is only read after select rose, when the link is idle.
    assign new_ctl = pcw_ctl_t'(ser.word[`PCW_CTL_HI:`PCW_CTL_LO]);

    always_comb begin
        n = q;
        n.cs_s1  = cs_n_in;
        n.cs_s2  = q.cs_s1;
        n.cs_prev = q.cs_s2;
        n.ld_s1  = load_n_in;
        n.ld_s2  = q.ld_s1;
        n.cen_s1 = comp_enable_in;
        n.cen_s2 = q.cen_s1;
        n.fp_s1  = measure_float_pin_in;
        n.fp_s2  = q.fp_s1;
        n.up_s1  = upper_threshold_in;
        n.up_s2  = q.up_s1;
        n.lo_s1  = lower_threshold_in;
        n.lo_s2  = q.lo_s1;
        n.cnt_s1 = ser.edge_gray;
        n.cnt_s2 = q.cnt_s1;
        n.od_low = 2'h0;

        if (cs_fall) begin
            n.cnt_snap = q.cnt_s2;
        end

        if (cs_rise) begin
            if (quiet) begin
                n.pmu_reg = q.in_reg;
            end else begin
                for (int u = 0; u < 2; u++) begin
                    if (ser.word[`PCW_ADDR_LO + u]) begin
                        n.in_reg[u] = new_ctl;
                    end
                    if (ser.word[`PCW_XFER_LO + u]) begin
                        n.pmu_reg[u] = n.in_reg[u];
                    end
                end
            end
        end

        // Load pin held low makes the unit registers transparent.
        if (!q.ld_s2) begin
            n.pmu_reg = n.in_reg;
        end

        for (int u = 0; u < 2; u++) begin
            n.range_idx[u] = pcw_range_idx(q.pmu_reg[u].range_sel);
            n.boost[u]  = (q.pmu_reg[u].range_sel == `PCW_RS_EXT);
            n.clamp[u]  = q.pmu_reg[u].clamp_enable_bit;
            n.f_oe[u]   = q.pmu_reg[u].force_drive;
            n.f_cur[u]  = q.pmu_reg[u].force_current_mode;
            n.in_sel[u] = q.pmu_reg[u].input_sel;
            n.m_cur[u]  = ~q.pmu_reg[u].measure_voltage_mode;
            n.m_oe[u]   = q.pmu_reg[u].measure_float_bit & q.fp_s2[u];
            // Open drain: a flag reads 1 when released, 0 when pulled.
            n.h_oe[u]   = q.cen_s2 & q.up_s2[u];
            n.l_oe[u]   = q.cen_s2 & q.lo_s2[u];
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            q <= PCW_STATE_RST;
        end else if (ce_in) begin
            q <= n;
        end
    end

    assign dout_out                 = ser.dout;
    assign range_sel_out            = q.range_idx;
    assign booster_select_out       = q.boost;
    assign clamp_enable_out         = q.clamp;
    assign force_oe_out             = q.f_oe;
    assign force_current_mode_out   = q.f_cur;
    assign input_sel_out            = q.in_sel;
    assign measure_oe_out           = q.m_oe;
    assign measure_current_mode_out = q.m_cur;
    assign high_flag_out            = q.od_low;
    assign high_flag_oe_out         = q.h_oe;
    assign low_flag_out             = q.od_low;
    assign low_flag_oe_out          = q.l_oe;

    default clocking dc @(posedge clock_in);
    endclocking
    default disable iff (rst_in);

    sequence s_quiet_frame;
        cs_rise && quiet && ce_in;
    endsequence

    sequence s_load_frame(int u);
        cs_rise && !quiet && ce_in && ser.word[`PCW_ADDR_LO + u]
            && ser.word[`PCW_XFER_LO + u];
    endsequence

    generate
        for (genvar g = 0; g < 2; g++) begin : g_chk
            boost_sel_a: assert property (
                ce_in && q.pmu_reg[g].range_sel == `PCW_RS_EXT
                |=> booster_select_out[g])
                else $error("booster select missing for external range");

            range_low_a: assert property (
                ce_in && q.pmu_reg[g].range_sel[2:1] == 2'h0
                |=> range_sel_out[g] == `PCW_IDX_2UA)
                else $error("lowest range not selected");

            clamp_out_a: assert property (
                ce_in |=> clamp_enable_out[g]
                    == $past(q.pmu_reg[g].clamp_enable_bit))
                else $error("clamp enable does not follow unit bit");

            meas_float_a: assert property (
                ce_in && !(q.pmu_reg[g].measure_float_bit && q.fp_s2[g])
                |=> !measure_oe_out[g])
                else $error("measure output driven while floated");

            comp_off_a: assert property (
                ce_in && !q.cen_s2 |=> !high_flag_oe_out[g]
                    && !low_flag_oe_out[g])
                else $error("comparator flag driven while disabled");

            comp_both_a: assert property (
                ce_in && q.cen_s2 && q.up_s2[g] && q.lo_s2[g]
                |=> high_flag_oe_out[g] && low_flag_oe_out[g]
                    && !high_flag_out[g] && !low_flag_out[g])
                else $error("inverted window flags not both low");

            force_off_a: assert property (
                ce_in && !q.pmu_reg[g].force_drive |=> !force_oe_out[g])
                else $error("force output driven in force nothing");

            word_load_a: assert property (
                s_load_frame(g) |=> q.pmu_reg[g] == $past(new_ctl))
                else $error("word not transferred on select rise");

            quick_load_a: assert property (
                s_quiet_frame |=> q.pmu_reg[g] == $past(q.in_reg[g]))
                else $error("quick load did not transfer input register");

            hold_a: assert property (
                ce_in && !cs_rise && q.ld_s2 |=> $stable(q.pmu_reg[g]))
                else $error("unit register changed without transfer");
        end
    endgenerate

    reset_hiz_a: assert property (
        @(posedge clock_in) disable iff (1'b0)
        rst_in |=> force_oe_out == 2'h0 && measure_oe_out == 2'h0
            && high_flag_oe_out == 2'h0 && low_flag_oe_out == 2'h0)
        else $error("outputs not floating after reset");

endmodule : pcw_ctrl_top

// ---- tb/pcw_host_model.sv ----
// Purpose: Host model that drives serial frames into the decoder.
// Assumes: Link clock of 30 ns that stands low between frames.
// Notes:   The data line is toggled while deselected.
module pcw_host_model (
    output logic      sclk_out,
    output logic      din_out,
    output logic      cs_n_out,
    input  wire logic dout_in
);
    timeunit 1ns;
    timeprecision 100ps;

    logic dq [$];

    initial begin
        sclk_out = 1'b0;
        din_out  = 1'b0;
        cs_n_out = 1'b1;
    end

    // Sends the low n bits of w, most significant first.
    task automatic send(input logic [31:0] w, input int n);
        cs_n_out = 1'b0;
        dq.delete();
        #100;
        for (int i = n - 1; i >= 0; i--) begin
            din_out = w[i];
            #14 sclk_out = 1'b1;
            #15 sclk_out = 1'b0;
            #1 dq.push_back(dout_in);
        end
        #100 cs_n_out = 1'b1;
        din_out = ~din_out;
        #120;
    endtask : send

    // Select pulse with the link clock standing still.
    task automatic quick_load();
        cs_n_out = 1'b0;
        #200 cs_n_out = 1'b1;
        #120;
    endtask : quick_load
endmodule : pcw_host_model

// ---- tb/pmu_control_word_decode_tb.sv ----
// Purpose: Self-checking bench of the control word decoder.
// Assumes: Outputs settle within five system clocks of a transfer.
// Notes:   Flags are resolved against a pull-up in the bench.
module pmu_control_word_decode_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import pcw_pkg::*;

    logic            clock_in = 1'b0;
    logic            rst_in = 1'b0;
    logic            ce_in = 1'b1;
    logic            load_n_in = 1'b1;
    logic            comp_enable_in = 1'b0;
    logic [1:0]      measure_float_pin_in = '0;
    logic [1:0]      upper_threshold_in = '0;
    logic [1:0]      lower_threshold_in = '0;
    logic            sclk_in, din_in, cs_n_in, dout_out;
    logic [1:0][2:0] range_sel_out;
    logic [1:0]      booster_select_out, clamp_enable_out, force_oe_out;
    logic [1:0]      force_current_mode_out, input_sel_out;
    logic [1:0]      measure_oe_out, measure_current_mode_out;
    logic [1:0]      high_flag_out, high_flag_oe_out;
    logic [1:0]      low_flag_out, low_flag_oe_out;
    logic [8:0]      inr [2] = '{default: '0};
    logic [8:0]      pmr [2] = '{default: '0};
    logic [31:0]     w;
    int              n_fail = 0;
    int              num_checks = 0;
    int              cyc = 0;

    pcw_ctrl_top i_pcw_ctrl_top (
        .clock_in                (clock_in),
        .rst_in                  (rst_in),
        .ce_in                   (ce_in),
        .sclk_in                 (sclk_in),
        .din_in                  (din_in),
        .cs_n_in                 (cs_n_in),
        .load_n_in               (load_n_in),
        .comp_enable_in          (comp_enable_in),
        .measure_float_pin_in    (measure_float_pin_in),
        .upper_threshold_in      (upper_threshold_in),
        .lower_threshold_in      (lower_threshold_in),
        .dout_out                (dout_out),
        .range_sel_out           (range_sel_out),
        .booster_select_out      (booster_select_out),
        .clamp_enable_out        (clamp_enable_out),
        .force_oe_out            (force_oe_out),
        .force_current_mode_out  (force_current_mode_out),
        .input_sel_out           (input_sel_out),
        .measure_oe_out          (measure_oe_out),
        .measure_current_mode_out(measure_current_mode_out),
        .high_flag_out           (high_flag_out),
        .high_flag_oe_out        (high_flag_oe_out),
        .low_flag_out            (low_flag_out),
        .low_flag_oe_out         (low_flag_oe_out)
    );

    pcw_host_model i_pcw_host_model (
        .sclk_out(sclk_in),
        .din_out (din_in),
        .cs_n_out(cs_n_in),
        .dout_in (dout_out)
    );

    initial begin
        forever #10 clock_in = ~clock_in;
    end

    task automatic stop_test();
        if (n_fail == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            stop_test();
        end
    end

    task automatic check(input logic [7:0] seen, exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask : check

    function automatic logic [2:0] exp_idx(input logic [2:0] rs);
        if (rs < 3'h2) return 3'h0;
        if (rs == 3'h6) return 3'h5;
        if (rs == 3'h7) return 3'h4;
        return rs - 3'h1;
    endfunction : exp_idx

    // The record c holds word bits 12..4 of the active unit register.
    task automatic check_units();
        logic [8:0] c;
        for (int u = 0; u < 2; u++) begin
            c = pmr[u];
            check(range_sel_out[u], exp_idx(c[8:6]), "range");
            check(booster_select_out[u], c[8:6] == 3'h6, "booster");
            check(clamp_enable_out[u], c[4], "clamp");
            check(force_oe_out[u], c[3], "force drive");
            check(force_current_mode_out[u], c[2], "force mode");
            check(input_sel_out[u], c[0], "input select");
            check(measure_oe_out[u], c[5] & measure_float_pin_in[u],
                  "measure drive");
            check(measure_current_mode_out[u], !c[1], "measure mode");
        end
    endtask : check_units

    task automatic frame(input logic [31:0] fw, input int n);
        i_pcw_host_model.send(fw, n);
        for (int u = 0; u < 2; u++) begin
            if (fw[2+u]) inr[u] = fw[12:4];
            if (fw[u]) pmr[u] = inr[u];
        end
        repeat (5) @(posedge clock_in);
        #1;
        check_units();
    endtask : frame

    initial begin
        // A rising reset also clears the link logic while its clock is still.
        rst_in <= 1'b1;
        void'($urandom(32'h83d26e1b));
        repeat (12) @(posedge clock_in);
        rst_in <= 1'b0;
        repeat (5) @(posedge clock_in);
        #1;
        check(dout_out, 1'b0, "dout after reset");
        check(high_flag_oe_out | low_flag_oe_out, 2'h0, "flag float");
        check_units();
        for (int rs = 0; rs < 8; rs++) begin
            @(posedge clock_in);
            measure_float_pin_in <= 2'($urandom());
            w = $urandom();
            w[12:10] = 3'(rs);
            w[3:0] = 4'hf;
            frame(w, 16);
        end
        // Every address and transfer combination, NOP included.
        for (int k = 0; k < 16; k++) begin
            w = $urandom();
            w[3:0] = 4'(k);
            frame(w, 16);
        end
        w = $urandom();
        w[3:0] = 4'hc;
        frame(w, 16);
        i_pcw_host_model.quick_load();
        pmr = inr;
        repeat (5) @(posedge clock_in);
        #1;
        check_units();
        w = $urandom();
        w[3:0] = 4'hc;
        frame(w, 16);
        @(posedge clock_in);
        load_n_in <= 1'b0;
        pmr = inr;
        repeat (5) @(posedge clock_in);
        #1;
        check_units();
        load_n_in <= 1'b1;
        w = $urandom();
        w[3:0] = 4'h0;
        frame(w, 32);
        for (int j = 15; j < 32; j++) begin
            check(i_pcw_host_model.dq[j], w[46-j], "daisy data");
        end
        for (int i = 0; i < 24; i++) begin
            @(posedge clock_in);
            comp_enable_in <= (i < 4) ? 1'b1 : 1'($urandom());
            upper_threshold_in <= (i < 4) ? 2'(i) : 2'($urandom());
            lower_threshold_in <= (i < 4) ? 2'(i) : 2'($urandom());
            repeat (4) @(posedge clock_in);
            #1;
            for (int u = 0; u < 2; u++) begin
                check(high_flag_oe_out[u],
                      comp_enable_in & upper_threshold_in[u],
                      "high flag drive");
                check(low_flag_oe_out[u],
                      comp_enable_in & lower_threshold_in[u],
                      "low flag drive");
                check(high_flag_oe_out[u] ? high_flag_out[u] : 1'b1,
                      !(comp_enable_in & upper_threshold_in[u]),
                      "high flag level");
                check(low_flag_oe_out[u] ? low_flag_out[u] : 1'b1,
                      !(comp_enable_in & lower_threshold_in[u]),
                      "low flag level");
            end
        end
        stop_test();
    end
endmodule : pmu_control_word_decode_tb
